// >>> rtl/lrcr_defines.vh
`ifndef LRCR_DEFINES_VH
`define LRCR_DEFINES_VH

// Register pointer values
`define LRCR_PTR_RESULT      8'h00
`define LRCR_PTR_CONFIG      8'h01

// Result register fields
`define LRCR_RES_EXP_HI      15
`define LRCR_RES_EXP_LO      12
`define LRCR_RES_MANT_HI     11
`define LRCR_RES_MANT_LO     0
`define LRCR_RES_RESET       16'h0000

// Configuration register fields
`define LRCR_CFG_RANGE_HI    15
`define LRCR_CFG_RANGE_LO    12
`define LRCR_CFG_CT          11
`define LRCR_CFG_MODE_HI     10
`define LRCR_CFG_MODE_LO     9
`define LRCR_CFG_OVF         8
`define LRCR_CFG_CRF         7
`define LRCR_CFG_FH          6
`define LRCR_CFG_FL          5
`define LRCR_CFG_LATCH       4
`define LRCR_CFG_POL         3
`define LRCR_CFG_ME          2
`define LRCR_CFG_FC_HI       1
`define LRCR_CFG_FC_LO       0
`define LRCR_CFG_RESET       16'hC810
`define LRCR_CFG_WR_MASK     16'hFE1F

// Range and mode codes
`define LRCR_RANGE_AUTO      4'hC
`define LRCR_MODE_OFF        2'h0
`define LRCR_MODE_SINGLE     2'h1

// Conversion timing
`define LRCR_CLK_KHZ         50000
`define LRCR_CONV_SHORT_MS   100
`define LRCR_CONV_LONG_MS    800
`define LRCR_CONV_SHORT_CYC  (`LRCR_CONV_SHORT_MS * `LRCR_CLK_KHZ)
`define LRCR_CONV_LONG_CYC   (`LRCR_CONV_LONG_MS * `LRCR_CLK_KHZ)

`endif

// >>> rtl/lrcr_regs.v
// Functional notes
// - Each finished conversion overwrites the result register with its outcome.
// - Result holds exponent in bits 15:12 and mantissa in bits 11:0.
// - Mantissa is unsigned binary from zero to the range full scale.
// - Exponent codes 0 to 11 give twelve doubling ranges, 81.90 to 167731.2 lux.
// - Lux equals mantissa times 0.02 times two to the exponent.
// - Exponent mask with a manual range code 0 to 11 reports exponent zero.
// - Any configuration write aborts a running conversion at once.
// - After that write a new conversion starts if the mode asks for one.
// - Configuration bits 15:12 select the range with the exponent code set.
// - Range code 1100b means automatic range, reported in the result exponent.
// - Range select resets to 1100b, automatic mode.
// - Configuration register holds eleven fields at their fixed positions.
// - Result register is read-only; writes leave it unchanged.
// - Overflow, ready, high and low flags are read-only; others read and write.
// - Registers travel as two bytes, most significant byte first.
// - The register pointer is kept until the host writes a new one.
// - Conversion time bit selects 100 ms when clear, 800 ms when set.
// - Mode resets to shutdown; 01 is single shot, 10 and 11 continuous.
`timescale 1ns/10ps
`default_nettype none
`include "lrcr_defines.vh"

module lrcr_regs #(
    parameter         CNT_W          = 26,
    parameter [25:0]  CONV_SHORT_CYC = `LRCR_CONV_SHORT_CYC,
    parameter [25:0]  CONV_LONG_CYC  = `LRCR_CONV_LONG_CYC
) (
    // Clock and reset
    input  wire        ref_clk_i,
    input  wire        rstn_i,
    // Byte port from the serial bus controller
    input  wire        ptr_wr_i,
    input  wire [7:0]  ptr_i,
    input  wire        wr_byte_i,
    input  wire [7:0]  wr_data_i,
    input  wire        rd_start_i,
    input  wire        rd_byte_i,
    output reg  [7:0]  rd_data_o,
    // Converter interface
    input  wire [3:0]  adc_exp_i,
    input  wire [11:0] adc_mant_i,
    input  wire        adc_ovf_i,
    input  wire        upper_limit_i,
    input  wire        lower_limit_i,
    output wire        conv_active_o,
    output wire        conv_sample_o,
    output wire        conv_abort_o,
    output wire [3:0]  range_select_o,
    output wire        range_auto_o,
    output wire        conversion_length_sel_o
);

    // One-hot conversion states
    localparam [1:0] ST_IDLE = 2'b01;
    localparam [1:0] ST_CONV = 2'b10;

    // Reset image and host-writable bits of the configuration word
    localparam [15:0] CFG_RST = `LRCR_CFG_RESET;
    localparam [15:0] WR_MASK = `LRCR_CFG_WR_MASK;

    // Byte port behaviour
    // A write transaction is a pointer byte followed by up to two data bytes.
    // The pointer byte always updates the kept pointer, even before a read.
    // The first data byte is parked; the second one commits the whole word.
    // A lone first byte never reaches any field, so half words cannot land.
    // Bytes after the second are dropped until the next pointer byte.
    // Only the configuration pointer accepts data; all others ignore it.
    // Read-only bits of the word are replaced by their current value on commit.

    // A read transaction snapshots the pointed register at its start pulse.
    // Each byte request then shows the next half, high half first.
    // A third request wraps back to the high half of the same snapshot.
    // The snapshot is why a result landing mid-read cannot tear the pair.
    // Unmapped pointers read as zero.

    // Converter handshake
    // conv_active_o is high for every cycle of a running conversion.
    // conv_sample_o marks the last cycle; exponent, mantissa and overflow
    // from the converter are taken at that edge and nowhere else.
    // conv_abort_o marks a committed write that cut a running conversion.
    // A conversion end that meets a committed write is thrown away.
    // The count runs from the commit edge to the sample cycle inclusive.
    // Continuous mode reloads the count at once, with no idle gap.
    // Single shot drops the mode back to shutdown at its sample edge.

    // Timing
    // A committed write shows its fields from the next cycle on.
    // Read data is registered and stands until the next byte request.
    // The ready flag clears at the start of a configuration read.

    // Limitations
    // The limit comparison lives outside; its two flags are shown live.
    // Automatic ranging happens in the converter; only the code is reported.
    // Reserved range codes are kept as written and behave as manual ranges, except that the exponent mask does not zero them.
    // The counter is sized for the long conversion at 50 MHz;
    // a faster clock needs a wider CNT_W.

    // Sequencer state
    reg [1:0]       state_r;
    reg [CNT_W-1:0] cnt_r;
    // Byte port state
    reg [7:0]       ptr_r;
    reg             wr_msb_pend_r;
    reg             wr_lsb_pend_r;
    reg [7:0]       wr_msb_r;
    reg [15:0]      rd_shadow_r;
    reg             rd_lsb_r;
    // Result and configuration fields
    reg [15:0]      result_r;
    reg [3:0]       range_select_r;
    reg             conversion_length_sel_r;
    reg [1:0]       mode_r;
    reg             overrange_flag_r;
    reg             conversion_done_flag_r;
    reg             latch_r;
    reg             irq_polarity_r;
    reg             exponent_mask_on_r;
    reg [1:0]       fault_count_sel_r;

    wire [15:0] cfg_val;
    wire [15:0] cfg_new;
    wire [15:0] cfg_merged;
    wire        cfg_wr;
    wire        conv_end;
    wire        range_auto;
    wire [3:0]  exp_rep;
    wire [CNT_W-1:0] conv_len;
    wire [CNT_W-1:0] cfg_len;

    // Length of the conversion a committed write starts
    assign cfg_len = cfg_merged[`LRCR_CFG_CT] ? CONV_LONG_CYC : CONV_SHORT_CYC;

    // Configuration image as seen by the host
    assign cfg_val = {range_select_r, conversion_length_sel_r, mode_r,
                      overrange_flag_r, conversion_done_flag_r,
                      upper_limit_i, lower_limit_i, latch_r,
                      irq_polarity_r, exponent_mask_on_r, fault_count_sel_r};

    // Write data merged so read-only fields keep their value
    assign cfg_new    = {wr_msb_r, wr_data_i};
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi = gi + 1) begin : g_merge
            assign cfg_merged[gi] = WR_MASK[gi] ? cfg_new[gi] : cfg_val[gi];
        end
    endgenerate
    assign cfg_wr     = wr_byte_i && wr_lsb_pend_r &&
                        (ptr_r == `LRCR_PTR_CONFIG);

    // Conversion control
    assign range_auto = (range_select_r == `LRCR_RANGE_AUTO);
    assign conv_len   = conversion_length_sel_r ? CONV_LONG_CYC :
                                                  CONV_SHORT_CYC;
    assign conv_end   = state_r[1] && (cnt_r == {CNT_W{1'b0}});
    assign conv_abort_o  = cfg_wr && state_r[1];
    assign conv_sample_o = conv_end && !cfg_wr;
    assign conv_active_o = state_r[1];
    assign range_select_o          = range_select_r;
    assign range_auto_o            = range_auto;
    assign conversion_length_sel_o = conversion_length_sel_r;

    // Exponent reported with the result
    assign exp_rep = (exponent_mask_on_r && range_select_r < `LRCR_RANGE_AUTO) ? 4'h0 :
                     (range_auto ? adc_exp_i : range_select_r);

    // Pointer and write byte sequencing
    always @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            ptr_r         <= `LRCR_PTR_RESULT;
            wr_msb_pend_r <= 1'b0;
            wr_lsb_pend_r <= 1'b0;
            wr_msb_r      <= 8'h00;
        end else if (ptr_wr_i) begin
            ptr_r         <= ptr_i;
            wr_msb_pend_r <= 1'b1;
            wr_lsb_pend_r <= 1'b0;
        end else if (wr_byte_i && wr_msb_pend_r) begin
            wr_msb_r      <= wr_data_i;
            wr_msb_pend_r <= 1'b0;
            wr_lsb_pend_r <= 1'b1;
        end else if (wr_byte_i && wr_lsb_pend_r) begin
            wr_lsb_pend_r <= 1'b0;
        end
    end

    // Read snapshot keeps both bytes of a read coherent
    always @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            rd_shadow_r <= 16'h0000;
            rd_lsb_r    <= 1'b0;
            rd_data_o   <= 8'h00;
        end else if (rd_start_i) begin
            rd_lsb_r <= 1'b0;
            if (ptr_r == `LRCR_PTR_RESULT) begin
                rd_shadow_r <= result_r;
            end else if (ptr_r == `LRCR_PTR_CONFIG) begin
                rd_shadow_r <= cfg_val;
            end else begin
                rd_shadow_r <= 16'h0000;
            end
        end else if (rd_byte_i) begin
            rd_data_o <= rd_lsb_r ? rd_shadow_r[7:0] : rd_shadow_r[15:8];
            rd_lsb_r  <= ~rd_lsb_r;
        end
    end

    // Range, time and interrupt set-up fields; only a full two-byte write lands
    always @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            range_select_r          <= CFG_RST[`LRCR_CFG_RANGE_HI:`LRCR_CFG_RANGE_LO];
            conversion_length_sel_r <= CFG_RST[`LRCR_CFG_CT];
            latch_r                 <= CFG_RST[`LRCR_CFG_LATCH];
            irq_polarity_r          <= CFG_RST[`LRCR_CFG_POL];
            exponent_mask_on_r      <= CFG_RST[`LRCR_CFG_ME];
            fault_count_sel_r       <= CFG_RST[`LRCR_CFG_FC_HI:`LRCR_CFG_FC_LO];
        end else if (cfg_wr) begin
            // Reserved range codes are stored as written
            range_select_r          <= cfg_merged[`LRCR_CFG_RANGE_HI:`LRCR_CFG_RANGE_LO];
            conversion_length_sel_r <= cfg_merged[`LRCR_CFG_CT];
            latch_r                 <= cfg_merged[`LRCR_CFG_LATCH];
            irq_polarity_r          <= cfg_merged[`LRCR_CFG_POL];
            exponent_mask_on_r      <= cfg_merged[`LRCR_CFG_ME];
            fault_count_sel_r       <= cfg_merged[`LRCR_CFG_FC_HI:`LRCR_CFG_FC_LO];
        end
    end

    // Mode field; a finished single shot falls back to shutdown by itself
    always @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            mode_r <= CFG_RST[`LRCR_CFG_MODE_HI:`LRCR_CFG_MODE_LO];
        end else if (cfg_wr) begin
            mode_r <= cfg_merged[`LRCR_CFG_MODE_HI:`LRCR_CFG_MODE_LO];
        end else if (conv_end && mode_r == `LRCR_MODE_SINGLE) begin
            mode_r <= `LRCR_MODE_OFF;
        end
    end

    // Status flags; a conversion end in the cycle of a clearing read wins
    always @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            overrange_flag_r       <= CFG_RST[`LRCR_CFG_OVF];
            conversion_done_flag_r <= CFG_RST[`LRCR_CFG_CRF];
        end else if (conv_sample_o) begin
            overrange_flag_r       <= adc_ovf_i;
            conversion_done_flag_r <= 1'b1;
        end else if (rd_start_i && ptr_r == `LRCR_PTR_CONFIG) begin
            conversion_done_flag_r <= 1'b0;
        end
    end

    // Result capture; an aborted conversion never reaches the register
    always @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            result_r <= `LRCR_RES_RESET;
        end else if (conv_sample_o) begin
            result_r <= {exp_rep, adc_mant_i};
        end
    end

    // Conversion sequencer and cycle counter
    always @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            state_r <= ST_IDLE;
            cnt_r   <= {CNT_W{1'b0}};
        end else if (cfg_wr) begin
            // A write aborts any running conversion; a mode other than shutdown restarts the full count
            if (cfg_merged[`LRCR_CFG_MODE_HI:`LRCR_CFG_MODE_LO] != `LRCR_MODE_OFF) begin
                state_r <= ST_CONV;
                cnt_r   <= cfg_len - 1'b1;
            end else begin
                state_r <= ST_IDLE;
            end
        end else begin
            case (state_r)
                ST_IDLE: begin
                    state_r <= ST_IDLE;
                end
                ST_CONV: begin
                    if (conv_end && mode_r == `LRCR_MODE_SINGLE) begin
                        state_r <= ST_IDLE;
                    end else if (conv_end) begin
                        cnt_r <= conv_len - 1'b1;
                    end else begin
                        cnt_r <= cnt_r - 1'b1;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

endmodule
`default_nettype wire

// >>> test/lrcr_checker.sv
`timescale 1ns/10ps
`default_nettype none
module lrcr_checker #(
    parameter int CONV_SHORT_CYC = 20,
    parameter int CONV_LONG_CYC  = 80
) (
    // Clock, reset and byte port
    input wire logic       ref_clk_i,
    input wire logic       rstn_i,
    input wire logic       ptr_wr_i,
    input wire logic [7:0] ptr_i,
    input wire logic       wr_byte_i,
    input wire logic [7:0] wr_data_i,
    input wire logic       rd_byte_i,
    input wire logic [7:0] rd_data_o,
    // Converter side
    input wire logic       conv_active_o,
    input wire logic       conv_sample_o,
    input wire logic       conv_abort_o,
    input wire logic [3:0] range_select_o,
    input wire logic       range_auto_o,
    input wire logic       conversion_length_sel_o
);
    logic [25:0] cnt_r;
    logic [5:0]  hi1_r;
    logic [5:0]  hi2_r;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);
    // Cycles of the running conversion, and range, time and mode-active bits of the high data byte two cycles late
    always_ff @(posedge ref_clk_i) begin
        cnt_r <= (!conv_active_o || conv_sample_o || conv_abort_o) ? 26'h1 : cnt_r + 26'h1;
        hi1_r <= {wr_data_i[7:3], |wr_data_i[2:1]};
        hi2_r <= hi1_r;
    end
    sequence cfg_wr_s;
        ptr_wr_i && ptr_i == 8'h01 ##1 wr_byte_i && !ptr_wr_i ##1 wr_byte_i && !ptr_wr_i;
    endsequence
    AST_ABORT_ACT: assert property (conv_abort_o |-> conv_active_o && !conv_sample_o)
        else $error("abort outside a running conversion");
    AST_SAMPLE_ACT: assert property (conv_sample_o |-> conv_active_o)
        else $error("result capture while idle");
    AST_LEN: assert property (conv_sample_o |->
        cnt_r == (conversion_length_sel_o ? CONV_LONG_CYC : CONV_SHORT_CYC))
        else $error("conversion length wrong");
    AST_WR_APPLY: assert property (cfg_wr_s |=>
        {range_select_o, conversion_length_sel_o, conv_active_o} == hi2_r)
        else $error("config write not applied");
    AST_WR_ABORT: assert property (cfg_wr_s ##0 conv_active_o |-> conv_abort_o)
        else $error("config write did not abort");
    AST_AUTO: assert property (range_auto_o == (range_select_o == 4'hC))
        else $error("auto range flag wrong");
    AST_RESET: assert property ($rose(rstn_i) |-> range_select_o == 4'hC
        && conversion_length_sel_o && !conv_active_o && rd_data_o == 8'h00)
        else $error("reset values wrong");
    AST_RD_HOLD: assert property (!rd_byte_i |=> $stable(rd_data_o))
        else $error("read byte changed without request");
endmodule
`default_nettype wire

// >>> test/lrcr_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module lrcr_host_model (
    // Clock and read data
    input  wire logic       ref_clk_i,
    input  wire logic [7:0] rd_data_i,
    // Byte requests
    output var logic        ptr_wr_o,
    output var logic [7:0]  ptr_o,
    output var logic        wr_byte_o,
    output var logic [7:0]  wr_data_o,
    output var logic        rd_start_o,
    output var logic        rd_byte_o
);
    // Idle bus at time zero
    initial begin
        {ptr_wr_o, wr_byte_o, rd_start_o, rd_byte_o} = 4'h0;
        {ptr_o, wr_data_o} = 16'h5AA5;
    end
    // Pointer byte, then n data bytes; released lines are inverted
    task automatic write(input logic [7:0] p, input int n, input logic [15:0] d);
        @(negedge ref_clk_i) {ptr_wr_o, ptr_o} = {1'b1, p};
        for (int i = 0; i < n; i++) begin
            @(negedge ref_clk_i) {ptr_wr_o, wr_byte_o, wr_data_o} = {2'b01, (i == 0) ? d[15:8] : d[7:0]};
        end
        @(negedge ref_clk_i) {ptr_wr_o, wr_byte_o, ptr_o, wr_data_o} = {2'b00, ~ptr_o, ~wr_data_o};
    endtask
    // Two-byte read of the register the pointer holds
    task automatic read(output logic [15:0] v);
        @(negedge ref_clk_i) rd_start_o = 1'b1;
        @(negedge ref_clk_i) {rd_start_o, rd_byte_o} = 2'b01;
        @(negedge ref_clk_i) v[15:8] = rd_data_i;
        @(negedge ref_clk_i) {rd_byte_o, v[7:0]} = {1'b0, rd_data_i};
    endtask
endmodule
`default_nettype wire

// >>> test/test_light_result_and_config_regs.sv
`timescale 1ns/10ps
`default_nettype none
`include "lrcr_defines.vh"
module test_light_result_and_config_regs;
    logic        ref_clk_i, rstn_i, ptr_wr, wr_byte, rd_start, rd_byte, act, smp, adc_ovf, up, lo;
    logic [7:0]  ptr, wr_data, rd_data;
    logic [3:0]  adc_exp;
    logic [11:0] adc_mant;
    logic [15:0] cfg_m, res_m, v;
    logic [1:0]  lim_m;
    integer      err_count = 0, check_count = 0, seed = 32'h50dc, n_cyc = 0;
    lrcr_regs #(.CONV_SHORT_CYC(20), .CONV_LONG_CYC(80)) DUT (
        .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .ptr_wr_i(ptr_wr), .ptr_i(ptr), .wr_byte_i(wr_byte),
        .wr_data_i(wr_data), .rd_start_i(rd_start), .rd_byte_i(rd_byte), .rd_data_o(rd_data),
        .adc_exp_i(adc_exp), .adc_mant_i(adc_mant), .adc_ovf_i(adc_ovf), .upper_limit_i(up),
        .lower_limit_i(lo), .conv_active_o(act), .conv_sample_o(smp), .conv_abort_o(),
        .range_select_o(), .range_auto_o(), .conversion_length_sel_o());
    lrcr_host_model host (.ref_clk_i(ref_clk_i), .rd_data_i(rd_data), .ptr_wr_o(ptr_wr), .ptr_o(ptr),
        .wr_byte_o(wr_byte), .wr_data_o(wr_data), .rd_start_o(rd_start), .rd_byte_o(rd_byte));
    // Clock and converter stimulus at time zero
    initial begin
        ref_clk_i = 1'b0;
        {adc_exp, adc_mant, adc_ovf, up, lo} = 19'h0;
        forever #10 ref_clk_i = ~ref_clk_i;
    end
    // Random converter outcome and limit levels
    always @(negedge ref_clk_i) {adc_exp, adc_mant, adc_ovf, up, lo} = 19'($random(seed));
    // Reference model of result capture and flag updates
    always @(posedge ref_clk_i) begin
        if (rd_start) lim_m = {up, lo};
        if (rstn_i && smp) begin
            res_m = {(cfg_m[15:12] == 4'hC) ? adc_exp : (cfg_m[2] ? 4'h0 : cfg_m[15:12]), adc_mant};
            cfg_m[8:7] = {adc_ovf, 1'b1};
            if (cfg_m[10:9] == 2'h1) cfg_m[10:9] = 2'h0;
        end
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr_cfg(input logic [15:0] d);
        host.write(8'h01, 2, d);
        cfg_m = (cfg_m & ~`LRCR_CFG_WR_MASK) | (d & `LRCR_CFG_WR_MASK);
    endtask
    // Point at a register, read it and compare with the model
    task automatic rd_chk(input logic [7:0] p);
        host.write(p, 0, 16'h0);
        host.read(v);
        chk(v, p[0] ? {cfg_m[15:7], lim_m, cfg_m[4:0]} : res_m);
        if (p[0]) cfg_m[7] = 1'b0;
    endtask
    task automatic wait_idle;
        for (int i = 0; i < 200 && act !== 1'b0; i++) @(negedge ref_clk_i);
        chk({15'h0, act}, 16'h0);
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Main sequence
    initial begin
        {rstn_i, cfg_m, res_m, lim_m} = {1'b0, `LRCR_CFG_RESET, 16'h0, 2'h0};
        repeat (10) @(negedge ref_clk_i);
        rstn_i = 1'b1;
        rd_chk(8'h01);
        host.write(8'h00, 2, 16'hFFFF);
        host.read(v);
        chk(v, res_m);
        for (int r = 0; r <= 12; r++) begin
            wr_cfg({r[3:0], 3'b001, 9'($random(seed))});
            wait_idle();
            rd_chk(8'h00);
            rd_chk(8'h01);
        end
        wr_cfg(16'h3C00);
        repeat (30) @(negedge ref_clk_i);
        wr_cfg(16'h3400);
        n_cyc = 0;
        while (smp !== 1'b1 && n_cyc < 100) begin
            @(negedge ref_clk_i);
            n_cyc++;
        end
        chk({15'h0, smp}, 16'h1);
        chk(n_cyc[15:0], 16'd19);
        repeat (3) @(negedge ref_clk_i);
        wr_cfg(16'h3000);
        wait_idle();
        rd_chk(8'h00);
        stop_test();
    end
    // Watchdog
    initial begin
        #400000;
        err_count++;
        stop_test();
    end
endmodule
bind lrcr_regs lrcr_checker #(.CONV_SHORT_CYC(CONV_SHORT_CYC), .CONV_LONG_CYC(CONV_LONG_CYC)) u_chk (
    .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .ptr_wr_i(ptr_wr_i), .ptr_i(ptr_i), .wr_byte_i(wr_byte_i),
    .wr_data_i(wr_data_i), .rd_byte_i(rd_byte_i), .rd_data_o(rd_data_o), .conv_active_o(conv_active_o),
    .conv_sample_o(conv_sample_o), .conv_abort_o(conv_abort_o), .range_select_o(range_select_o),
    .range_auto_o(range_auto_o), .conversion_length_sel_o(conversion_length_sel_o));
`default_nettype wire
